/* File: hw/icps_regs.vh */
/*
 constants for the two-wire control port slave: slave addresses, subaddress
 ranges, register lengths and bit counts.
 assumes it is included by the design file under hw/.
*/
`ifndef ICPS_REGS_VH
`define ICPS_REGS_VH

// 7-bit slave addresses for the two settings of the select pin
`define ICPS_ADDR_HI     7'h1B
`define ICPS_ADDR_LO     7'h1A

// subaddress that appends four bytes to an open long register
`define ICPS_APPEND_SUB  8'hFE

// first audio-processing subaddress and the filter-section range
`define ICPS_AUDIO_LO    8'h40
`define ICPS_BQ_LO       8'h51
`define ICPS_BQ_HI       8'h88

// bytes that each class of register needs before it counts as complete
`define ICPS_LEN_ONE     5'h01
`define ICPS_LEN_WORD    5'h04
`define ICPS_LEN_BQ      5'h14

// bytes an open incremental write must carry per transfer
`define ICPS_APPEND_BYTES 3'h4

// bits per byte on the wire
`define ICPS_BITS        4'h8

// staging buffer size in bytes and fifo shape
`define ICPS_STAGE_BYTES 20
`define ICPS_FIFO_W      41
`define ICPS_FIFO_DEPTH  16
`define ICPS_FIFO_AW     4

`endif

/* File: hw/icps_slave.v */
/*
 two-wire control port slave with a write fifo toward the register file.
 assumes the master drives scl, an external pullup on both lines, and a
 register file on clk that answers rd_sub with rd_data in the same cycle.
*/
// How it works
// R1: slave only, never holds scl low
// R2: works at 100 and 400 kbps
// R3: address 0x36 with pin high, 0x34 low
// R4: 7-bit address 0011011, read 0x37
// R5: 8-bit bytes, msb first, each acknowledged
// R6: start and stop seen with scl high
// R7: sda changes only while scl low
// R8: no limit on bytes per transfer
// R9: audio-processing registers take four-byte words only
// R10: reads stream bytes, missing bits read zero; the code passes all four rd_data bytes unmasked
// R11: filter section needs five words, else discarded
// R12: mixer coefficient completes after one word
// R13: sequential write fills successive subaddresses
// R14: only the incomplete last register discarded
// R15: acknowledge address, subaddress and each data byte; no ack for a data byte while a commit streams to the fifo
// R16: four bytes then stop leaves register open
// R17: append subaddress adds four bytes in order
// R18: register released only once fully gathered
// R19: flush on new subaddress, bad count, read
// R20: read is subaddress write, restart, read
// R21: no acknowledge for a foreign address
`timescale 1ns/1ns
`include "icps_regs.vh"

module icps_fifo #(
    parameter W     = `ICPS_FIFO_W,
    parameter DEPTH = `ICPS_FIFO_DEPTH,
    parameter AW    = `ICPS_FIFO_AW
) (
    input  wire         clk,
    input  wire         rst_n,
    input  wire         in_valid,
    output wire         in_ready,
    input  wire [W-1:0] in_data,
    output reg          out_valid_q,
    input  wire         out_ready,
    output reg  [W-1:0] out_data_q
);
    reg [W-1:0] mem_q [0:DEPTH-1];
    reg [AW-1:0] wp_q;
    reg [AW-1:0] rp_q;
    reg [AW:0]   cnt_q;
    wire         push;
    wire         pop;

    assign in_ready = (cnt_q != DEPTH[AW:0]);
    assign push     = in_valid & in_ready;
    // output stage refills whenever it is empty or being taken
    assign pop      = (cnt_q != {(AW+1){1'b0}}) & (~out_valid_q | out_ready);

    always @(posedge clk)
    begin
        if (push)
            mem_q[wp_q] <= in_data;
    end

    always @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            wp_q        <= {AW{1'b0}};
            rp_q        <= {AW{1'b0}};
            cnt_q       <= {(AW+1){1'b0}};
            out_valid_q <= 1'b0;
            out_data_q  <= {W{1'b0}};
        end
        else
        begin
            if (push)
                wp_q <= wp_q + {{(AW-1){1'b0}}, 1'b1};
            if (pop)
            begin
                rp_q        <= rp_q + {{(AW-1){1'b0}}, 1'b1};
                out_data_q  <= mem_q[rp_q];
                out_valid_q <= 1'b1;
            end
            else if (out_ready)
                out_valid_q <= 1'b0;
            if (push & ~pop)
                cnt_q <= cnt_q + {{AW{1'b0}}, 1'b1};
            else if (pop & ~push)
                cnt_q <= cnt_q - {{AW{1'b0}}, 1'b1};
        end
    end
endmodule // icps_fifo

module icps_slave (
    input  wire        clk,
    input  wire        arst_n,
    input  wire        scl_in,
    input  wire        sda_in,
    output reg         sda_out_q,
    output reg         sda_oe_q,
    input  wire        address_select_pin,
    output reg  [7:0]  rd_sub_q,
    input  wire [31:0] rd_data,
    output wire        wr_valid,
    input  wire        wr_ready,
    output wire [7:0]  wr_sub,
    output wire [31:0] wr_data,
    output wire        wr_last
);
    localparam S_IDLE = 3'h0;
    localparam S_RX   = 3'h1;
    localparam S_ACK  = 3'h2;
    localparam S_TX   = 3'h3;
    localparam S_RACK = 3'h4;

    localparam K_ADDR = 2'h0;
    localparam K_SUB  = 2'h1;
    localparam K_DATA = 2'h2;

    // bytes a subaddress needs before it may be committed
    function [4:0] icps_len;
        input [7:0] sub;
        begin
            if (sub >= `ICPS_BQ_LO && sub <= `ICPS_BQ_HI)
                icps_len = `ICPS_LEN_BQ; // R11
            else if (sub >= `ICPS_AUDIO_LO)
                icps_len = `ICPS_LEN_WORD; // R9 R12
            else
                icps_len = `ICPS_LEN_ONE; // R9
        end
    endfunction

    reg  [1:0]  rst_sync_q;
    wire        rst_n;
    reg  [1:0]  scl_sync_q;
    reg  [1:0]  sda_sync_q;
    reg  [1:0]  sel_sync_q;
    reg         scl_p_q;
    reg         sda_p_q;
    wire        scl_s;
    wire        sda_s;
    wire        scl_rise;
    wire        scl_fall;
    wire        start_det;
    wire        stop_det;

    reg  [2:0]  state_q;
    reg  [1:0]  kind_q;
    reg  [3:0]  bit_q;
    reg  [7:0]  sh_q;
    reg  [7:0]  tx_q;
    reg         rw_q;
    reg         mack_q;
    reg  [1:0]  rb_q;
    reg         wr_xact_q;
    reg  [2:0]  xb_q;

    reg  [7:0]  stage_q [0:`ICPS_STAGE_BYTES-1];
    reg  [4:0]  idx_q;
    reg  [4:0]  need_q;
    reg  [7:0]  cur_sub_q;
    reg         open_q;
    reg         append_q;

    reg         cm_go_q;
    reg  [7:0]  cm_sub_q;
    reg  [2:0]  cm_nw_q;
    reg         cm_one_q;
    reg         cm_act_q;
    reg  [2:0]  cm_w_q;
    wire        cm_busy;
    wire        cm_ready;
    wire [4:0]  wb;
    wire [31:0] cm_word;
    wire        cm_last;
    wire [7:0]  rd_byte;
    wire [`ICPS_FIFO_W-1:0] fifo_out;
    wire [6:0]  my_addr;
    wire        load_tx;

    // reset release through two flops
    always @(posedge clk or negedge arst_n)
    begin
        if (!arst_n)
            rst_sync_q <= 2'h0;
        else
            rst_sync_q <= {rst_sync_q[0], 1'b1};
    end
    assign rst_n = rst_sync_q[1];

    // pins pass two flops; logic reads the second copy, and for scl and sda also a one-cycle delayed copy of it
    always @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            scl_sync_q <= 2'h3;
            sda_sync_q <= 2'h3;
            sel_sync_q <= 2'h0;
            scl_p_q    <= 1'b1;
            sda_p_q    <= 1'b1;
        end
        else
        begin
            scl_sync_q <= {scl_sync_q[0], scl_in}; // R2
            sda_sync_q <= {sda_sync_q[0], sda_in};
            sel_sync_q <= {sel_sync_q[0], address_select_pin};
            scl_p_q    <= scl_sync_q[1];
            sda_p_q    <= sda_sync_q[1];
        end
    end
    assign scl_s     = scl_sync_q[1];
    assign sda_s     = sda_sync_q[1];
    assign scl_rise  = scl_s & ~scl_p_q;
    assign scl_fall  = ~scl_s & scl_p_q;
    assign start_det = scl_s & scl_p_q & sda_p_q & ~sda_s; // R6
    assign stop_det  = scl_s & scl_p_q & ~sda_p_q & sda_s; // R6

    assign my_addr = sel_sync_q[1] ? `ICPS_ADDR_HI : `ICPS_ADDR_LO; // R3 R4
    // every subaddress returns all four bytes of rd_data, msb byte first, none zeroed here
    assign rd_byte = rd_data[{~rb_q, 3'h0} +: 8]; // R10
    assign load_tx = (state_q == S_ACK && rw_q) || (state_q == S_RACK && mack_q);
    assign cm_busy = cm_go_q | cm_act_q;

    // scl is never driven, so no wait state can ever be inserted R1
    always @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            sda_out_q <= 1'b0;
            sda_oe_q  <= 1'b0;
            state_q   <= S_IDLE;
            kind_q    <= K_ADDR;
            bit_q     <= 4'h0;
            sh_q      <= 8'h00;
            tx_q      <= 8'h00;
            rw_q      <= 1'b0;
            mack_q    <= 1'b0;
            rb_q      <= 2'h0;
            rd_sub_q  <= 8'h00;
            wr_xact_q <= 1'b0;
            xb_q      <= 3'h0;
            idx_q     <= 5'h00;
            need_q    <= `ICPS_LEN_ONE;
            cur_sub_q <= 8'h00;
            open_q    <= 1'b0;
            append_q  <= 1'b0;
            cm_go_q   <= 1'b0;
            cm_sub_q  <= 8'h00;
            cm_nw_q   <= 3'h0;
            cm_one_q  <= 1'b0;
        end
        else
        begin
            cm_go_q <= 1'b0;
            if (start_det || stop_det)
            begin
                sda_oe_q  <= 1'b0;
                state_q   <= start_det ? S_RX : S_IDLE;
                kind_q    <= K_ADDR;
                bit_q     <= 4'h0;
                wr_xact_q <= 1'b0;
                xb_q      <= 3'h0;
                // keep a register open only after exactly four bytes R16 R17
                if (wr_xact_q && !(open_q && idx_q != 5'h00 && xb_q == `ICPS_APPEND_BYTES))
                begin
                    open_q   <= 1'b0; // R11 R14 R19
                    append_q <= 1'b0;
                    idx_q    <= 5'h00;
                end
            end
            else if (scl_rise)
            begin
                if (state_q == S_RX)
                begin
                    sh_q  <= {sh_q[6:0], sda_s}; // R5
                    bit_q <= bit_q + 4'h1;
                end
                else if (state_q == S_RACK)
                    mack_q <= ~sda_s; // R20
            end
            else if (scl_fall)
            begin
                if (load_tx)
                begin
                    tx_q     <= rd_byte; // R10
                    sda_oe_q <= ~rd_byte[7]; // R5 R7
                    bit_q    <= 4'h1;
                    state_q  <= S_TX;
                    rb_q     <= rb_q + 2'h1;
                    if (rb_q == 2'h3)
                        rd_sub_q <= rd_sub_q + 8'h01;
                end
                else
                begin
                    case (state_q)
                        S_RX:
                        begin
                            if (bit_q == `ICPS_BITS)
                            begin
                                bit_q <= 4'h0;
                                case (kind_q)
                                    K_ADDR:
                                    begin
                                        if (sh_q[7:1] == my_addr)
                                        begin
                                            sda_oe_q <= 1'b1; // R15
                                            state_q  <= S_ACK;
                                            rw_q     <= sh_q[0];
                                            kind_q   <= K_SUB;
                                            rb_q     <= 2'h0;
                                            if (sh_q[0])
                                            begin
                                                open_q   <= 1'b0; // R19 R20
                                                append_q <= 1'b0;
                                                idx_q    <= 5'h00;
                                            end
                                            else
                                                wr_xact_q <= 1'b1;
                                        end
                                        else
                                            state_q <= S_IDLE; // R21
                                    end
                                    K_SUB:
                                    begin
                                        sda_oe_q <= 1'b1; // R15
                                        state_q  <= S_ACK;
                                        kind_q   <= K_DATA;
                                        rd_sub_q <= sh_q;
                                        if (sh_q == `ICPS_APPEND_SUB)
                                            append_q <= 1'b1; // R17
                                        else
                                        begin
                                            cur_sub_q <= sh_q; // R13 R19
                                            need_q    <= icps_len(sh_q);
                                            idx_q     <= 5'h00;
                                            open_q    <= 1'b1;
                                            append_q  <= 1'b0;
                                        end
                                    end
                                    default:
                                    begin
                                        // no ack while the commit streamer is still copying a register into the fifo
                                        if (cm_busy)
                                            state_q <= S_IDLE;
                                        else
                                        begin
                                            sda_oe_q <= 1'b1; // R15
                                            state_q  <= S_ACK;
                                            if (xb_q != 3'h7)
                                                xb_q <= xb_q + 3'h1; // R8
                                            if (open_q)
                                            begin
                                                stage_q[idx_q] <= sh_q; // R17
                                                idx_q <= idx_q + 5'h01;
                                                if ((idx_q + 5'h01) == need_q)
                                                begin
                                                    cm_go_q  <= 1'b1; // R18
                                                    cm_sub_q <= cur_sub_q;
                                                    cm_nw_q  <= need_q[4:2] + {2'h0, |need_q[1:0]};
                                                    cm_one_q <= (need_q == `ICPS_LEN_ONE);
                                                    idx_q    <= 5'h00;
                                                    if (append_q)
                                                    begin
                                                        open_q   <= 1'b0;
                                                        append_q <= 1'b0;
                                                    end
                                                    else
                                                    begin
                                                        cur_sub_q <= cur_sub_q + 8'h01; // R13
                                                        need_q    <= icps_len(cur_sub_q + 8'h01);
                                                    end
                                                end
                                            end
                                        end
                                    end
                                endcase
                            end
                        end
                        S_ACK:
                        begin
                            sda_oe_q <= 1'b0; // R7
                            state_q  <= S_RX;
                        end
                        S_TX:
                        begin
                            if (bit_q == `ICPS_BITS)
                            begin
                                sda_oe_q <= 1'b0;
                                state_q  <= S_RACK;
                            end
                            else
                            begin
                                sda_oe_q <= ~tx_q[3'h7 - bit_q[2:0]]; // R5 R7
                                bit_q    <= bit_q + 4'h1;
                            end
                        end
                        S_RACK:
                            state_q <= S_IDLE; // R20
                        default:
                            state_q <= S_IDLE;
                    endcase
                end
            end
        end
    end

    // commit streamer: copies a finished register into the fifo word by word
    always @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            cm_act_q <= 1'b0;
            cm_w_q   <= 3'h0;
        end
        else if (cm_go_q)
        begin
            cm_act_q <= 1'b1;
            cm_w_q   <= 3'h0;
        end
        else if (cm_act_q && cm_ready)
        begin
            cm_w_q <= cm_w_q + 3'h1;
            if (cm_last)
                cm_act_q <= 1'b0;
        end
    end

    assign wb      = {cm_w_q[2:0], 2'h0};
    assign cm_last = (cm_w_q == cm_nw_q - 3'h1);
    assign cm_word = cm_one_q ? {24'h000000, stage_q[0]} :
                     {stage_q[wb], stage_q[wb + 5'h01], stage_q[wb + 5'h02], stage_q[wb + 5'h03]};

    icps_fifo #(
        .W     (`ICPS_FIFO_W),
        .DEPTH (`ICPS_FIFO_DEPTH),
        .AW    (`ICPS_FIFO_AW)
    ) u_fifo (
        .clk         (clk),
        .rst_n       (rst_n),
        .in_valid    (cm_act_q),
        .in_ready    (cm_ready),
        .in_data     ({cm_sub_q, cm_last, cm_word}),
        .out_valid_q (wr_valid),
        .out_ready   (wr_ready),
        .out_data_q  (fifo_out)
    );

    assign wr_sub  = fifo_out[40:33];
    assign wr_last = fifo_out[32];
    assign wr_data = fifo_out[31:0];
endmodule // icps_slave

/* File: tb/icps_bus_master.sv */
/* two-wire bus master model with frame and byte tasks.
   assumes the bench resolves sda with a pullup. */
`timescale 1ns/1ns
module icps_bus_master (
    input  wire logic clk,
    input  wire logic sda,
    output logic      scl,
    output logic      sda_low
);
    int half = 4; // scl phase in clk cycles, 160 ns period; the slave needs four at least
    initial
    begin
        scl = 1'b1;
        sda_low = 1'b0;
    end
    task automatic cyc(input int n);
        repeat (n) @(negedge clk);
    endtask
    // go=1 start or repeated start, go=0 stop; sda is set up with scl low, then moves with scl high
    task automatic frame(input logic go);
        cyc(1);
        sda_low = !go;
        cyc(half - 1);
        scl = 1'b1;
        cyc(half);
        sda_low = go;
        cyc(half);
        scl = !go;
    endtask
    // data moves one cycle after the fall, sampled late in the high phase
    task automatic bit_io(input logic o, output logic i);
        cyc(1);
        sda_low = !o;
        cyc(half - 1);
        scl = 1'b1;
        cyc(half);
        i = sda;
        scl = 1'b0;
    endtask
    task automatic wbyte(input logic [7:0] b, output logic ack);
        logic x;
        for (int k = 7; k >= 0; k--)
            bit_io(b[k], x);
        bit_io(1'b1, x);
        ack = !x;
    endtask
    task automatic rbyte(output logic [7:0] b, input logic ack);
        logic x;
        for (int k = 7; k >= 0; k--)
            bit_io(1'b1, b[k]);
        bit_io(!ack, x);
    endtask
endmodule // icps_bus_master

/* File: tb/icps_slave_props.sv */
/* checker for the two-wire control port slave, bound to its top ports.
   assumes a register file that takes one word per handshake. */
`timescale 1ns/1ns
module icps_slave_props (
    input wire logic        clk,
    input wire logic        arst_n,
    input wire logic        scl_in,
    input wire logic        sda_out_q,
    input wire logic        sda_oe_q,
    input wire logic        wr_valid,
    input wire logic        wr_ready,
    input wire logic [7:0]  wr_sub,
    input wire logic [31:0] wr_data,
    input wire logic        wr_last
);
    default clocking cb @(posedge clk); endclocking
    default disable iff (!arst_n);
    logic [4:0] widx_q;
    logic [7:0] wsub_q;
    wire        take  = wr_valid && wr_ready;
    wire        is_bq = wr_sub >= 8'h51 && wr_sub <= 8'h88;
    // word index within a register, so word counts can be judged at the last word
    always @(posedge clk or negedge arst_n)
    begin
        if (!arst_n)
        begin
            widx_q <= 5'h00;
            wsub_q <= 8'h00;
        end
        else if (take)
        begin
            widx_q <= wr_last ? 5'h00 : widx_q + 5'h01;
            wsub_q <= wr_sub;
        end
    end
    sda_open_drain_a: assert property (sda_out_q == 1'b0)
        else $error("sda driven high");
    oe_scl_low_a: assert property ($changed(sda_oe_q) |-> !scl_in && !$past(scl_in) && !$past(scl_in, 2))
        else $error("sda moved outside scl low");
    head_hold_a: assert property (wr_valid && !wr_ready |=> wr_valid && $stable({wr_sub, wr_data, wr_last}))
        else $error("write head changed before taken");
    one_byte_word_a: assert property (wr_valid && wr_sub < 8'h40 |-> wr_last && wr_data[31:8] == 24'h0)
        else $error("short register word malformed");
    bq_five_words_a: assert property (wr_valid && is_bq |-> wr_last == (widx_q == 5'h04))
        else $error("filter section not five words");
    mixer_one_word_a: assert property (wr_valid && wr_sub >= 8'h40 && !is_bq |-> wr_last && widx_q == 5'h00)
        else $error("coefficient not one word");
    no_append_sub_a: assert property (wr_valid |-> wr_sub != 8'hFE)
        else $error("append subaddress committed");
    same_sub_a: assert property (wr_valid && widx_q != 5'h00 |-> wr_sub == wsub_q)
        else $error("subaddress changed inside register");
    cover property (take && is_bq && wr_last);
    cover property (wr_valid && !wr_ready ##1 wr_valid);
    cover property ($rose(sda_oe_q));
endmodule // icps_slave_props

/* File: tb/tb_icps_slave.sv */
/* self-checking bench for the two-wire control port slave.
   assumes the master model and checker are compiled first. */
`timescale 1ns/1ns
module tb_icps_slave;
    logic        clk = 1'b0;
    logic        arst_n = 1'b0;
    logic        sel = 1'b1;
    logic        wr_ready = 1'b1;
    logic        scl, sda_low, sda_out_q, sda_oe_q, wr_valid, wr_last;
    logic [7:0]  rd_sub_q, wr_sub;
    logic [31:0] wr_data;
    logic [40:0] q[$];
    int          error_cnt = 0;
    int          checked = 0;
    int          acks;
    function automatic logic [31:0] rdw(input logic [7:0] s);
        return {s ^ 8'h3C, s, s + 8'h5A, ~s};
    endfunction
    wire         sda = !(sda_low || (sda_oe_q === 1'b1 && sda_out_q === 1'b0));
    wire  [31:0] rd_data = rdw(rd_sub_q);
    initial forever #10 clk = ~clk;
    icps_slave dut (
        .clk                (clk),
        .arst_n             (arst_n),
        .scl_in             (scl),
        .sda_in             (sda),
        .sda_out_q          (sda_out_q),
        .sda_oe_q           (sda_oe_q),
        .address_select_pin (sel),
        .rd_sub_q           (rd_sub_q),
        .rd_data            (rd_data),
        .wr_valid           (wr_valid),
        .wr_ready           (wr_ready),
        .wr_sub             (wr_sub),
        .wr_data            (wr_data),
        .wr_last            (wr_last)
    );
    icps_bus_master m (
        .clk     (clk),
        .sda     (sda),
        .scl     (scl),
        .sda_low (sda_low)
    );
    always @(posedge clk)
        if (wr_valid === 1'b1 && wr_ready === 1'b1)
            q.push_back({wr_sub, wr_data, wr_last});
    task automatic chk(input logic [63:0] seen, input logic [63:0] exp);
        checked++;
        if (seen !== exp)
        begin
            error_cnt++;
            $display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask
    task automatic complete_run();
        $display("comparisons %0d mismatches %0d", checked, error_cnt);
        if (error_cnt == 0 && checked > 0)
            $display("Testbench passed");
        else
            $display("Testbench failed");
        $finish;
    endtask
    // bounded wait for the next committed word, then compare it
    task automatic exp_w(input logic [7:0] s, input logic [31:0] d, input logic l);
        for (int k = 0; k < 400 && q.size() == 0; k++)
            @(negedge clk);
        if (q.size() == 0)
        begin
            chk(64'h0, 64'h1);
            complete_run();
        end
        else
            chk(q.pop_front(), {s, d, l});
    endtask
    task automatic txn(input logic [7:0] a, input logic [7:0] s, input int n, input logic [7:0] d0);
        logic ack;
        m.frame(1'b1);
        m.wbyte(a, ack);
        acks = ack;
        m.wbyte(s, ack);
        acks += ack;
        for (int k = 0; k < n; k++)
        begin
            m.wbyte(d0 + k[7:0], ack);
            acks += ack;
        end
        m.frame(1'b0);
    endtask
    task automatic t_single();
        txn(8'h36, 8'h05, 1, 8'hAB);
        chk(acks, 3);
        exp_w(8'h05, 32'h000000AB, 1'b1);
        $display("single write done");
    endtask
    task automatic t_select();
        sel = 1'b0;
        txn(8'h36, 8'h05, 1, 8'h11);
        chk(acks, 0);
        txn(8'h34, 8'h06, 1, 8'h22);
        chk(acks, 3);
        exp_w(8'h06, 32'h00000022, 1'b1);
        chk(q.size(), 0);
        sel = 1'b1;
        $display("address select done");
    endtask
    task automatic t_seq();
        txn(8'h36, 8'h3F, 7, 8'h10);
        chk(acks, 9);
        exp_w(8'h3F, 32'h00000010, 1'b1);
        exp_w(8'h40, 32'h11121314, 1'b1);
        m.cyc(60);
        chk(q.size(), 0);
        $display("sequential write done");
    endtask
    task automatic t_long();
        logic [7:0] b;
        txn(8'h36, 8'h51, 4, 8'h00);
        for (int k = 1; k < 5; k++)
        begin
            m.cyc(60);
            chk(q.size(), 0);
            txn(8'h36, 8'hFE, 4, {k[5:0], 2'b00});
            chk(acks, 6);
        end
        for (int j = 0; j < 5; j++)
        begin
            b = {j[5:0], 2'b00};
            exp_w(8'h51, {b, b + 8'h01, b + 8'h02, b + 8'h03}, j == 4);
        end
        $display("incremental write done");
    endtask
    // an open long register is flushed by a new subaddress, a bad count or a read
    task automatic t_flush(input int kind);
        logic [7:0] b;
        txn(8'h36, 8'h52, 4, 8'hA0);
        if (kind == 0)
        begin
            txn(8'h36, 8'h05, 1, 8'h77);
            exp_w(8'h05, 32'h00000077, 1'b1);
        end
        else if (kind == 1)
            txn(8'h36, 8'hFE, 3, 8'hB0);
        else
        begin
            m.frame(1'b1);
            m.wbyte(8'h37, b[0]);
            m.rbyte(b, 1'b0);
            m.frame(1'b0);
        end
        for (int k = 0; k < 4; k++)
            txn(8'h36, 8'hFE, 4, 8'hC0);
        m.cyc(60);
        chk(q.size(), 0);
        $display("flush case %0d done", kind);
    endtask
    // slow scl here, near the fast-mode rate
    task automatic t_read();
        logic        ack;
        logic [7:0]  b;
        logic [31:0] w;
        m.half = 63;
        m.frame(1'b1);
        m.wbyte(8'h36, ack);
        m.wbyte(8'h07, ack);
        m.frame(1'b1);
        m.wbyte(8'h37, ack);
        chk(ack, 1'b1);
        for (int k = 0; k < 6; k++)
        begin
            m.rbyte(b, k < 5);
            w = rdw(8'h07 + {2'b00, k[7:2]});
            chk(b, w[31 - 8 * (k % 4) -: 8]);
        end
        m.frame(1'b0);
        m.half = 5;
        $display("read done");
    endtask
    // consumer stalls until the fifo refuses, then drains it
    task automatic t_fill();
        wr_ready = 1'b0;
        txn(8'h36, 8'h00, 20, 8'h40);
        chk(acks >= 18 && acks < 22, 1'b1);
        m.cyc(40);
        wr_ready = 1'b1;
        for (int k = 0; k < acks - 2; k++)
            exp_w(k[7:0], {24'h0, 8'h40 + k[7:0]}, 1'b1);
        m.cyc(60);
        chk(q.size(), 0);
        $display("fifo fill done");
    endtask
    initial
    begin
        repeat (16) @(negedge clk);
        arst_n = 1'b1;
        m.cyc(8);
        t_single();
        t_select();
        t_seq();
        t_long();
        for (int k = 0; k < 3; k++)
            t_flush(k);
        t_read();
        t_fill();
        complete_run();
    end
    initial
    begin
        repeat (100000) @(posedge clk);
        chk(64'h0, 64'h1);
        complete_run();
    end
endmodule // tb_icps_slave
bind icps_slave icps_slave_props props (
    .clk       (clk),
    .arst_n    (arst_n),
    .scl_in    (scl_in),
    .sda_out_q (sda_out_q),
    .sda_oe_q  (sda_oe_q),
    .wr_valid  (wr_valid),
    .wr_ready  (wr_ready),
    .wr_sub    (wr_sub),
    .wr_data   (wr_data),
    .wr_last   (wr_last)
);
